/* File: hdl/art_prescaler.sv */
// 7-bit power-of-two prescaler with tap select
// assumes input_tick is a one-cycle pulse per input clock edge
`timescale 1ns/1ps
`include "art_params.svh"
module art_prescaler
    import art_pkg::*;
#(
    parameter int PSC_W = 7
) (
    // clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   rst_n_i,
    // control
    input  wire logic   tick_i,
    input  wire logic   clear_i,
    input  wire art_tap_t tap_i,
    // output
    output logic        count_tick_o
);
    // tap decode serves exactly seven stages
    if (PSC_W != 7) begin : g_bad_width
        $error("prescaler width must be 7");
    end

    logic [PSC_W-1:0] psc_r;
    logic [PSC_W:0]   ext_r;
    logic [PSC_W:0]   mask;

    assign ext_r = {1'b0, psc_r};
    // all low bits up to the tap are ones when the division period ends
    assign mask = ({{PSC_W{1'b0}}, 1'b1} << tap_i) - {{PSC_W{1'b0}}, 1'b1};

    assign count_tick_o = tick_i & ((ext_r & mask) == mask);

    // cleared on init, frozen without tick
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            psc_r <= `ART_PSC_ZERO;
        end else if (clear_i) begin
            psc_r <= `ART_PSC_ZERO;
        end else if (tick_i) begin
            psc_r <= psc_r + `ART_PSC_ONE;
        end
    end
endmodule : art_prescaler

/* File: hdl/art_pwm_chan.sv */
// one pwm channel: hidden compare register and output level
// assumes overflow and counter value come from the shared counter
`timescale 1ns/1ps
`include "art_params.svh"
module art_pwm_chan
    import art_pkg::*;
(
    // clock and reset
    input  wire logic      sys_clk_i,
    input  wire logic      rst_n_i,
    // counter side
    input  wire logic      ovf_i,
    input  wire art_byte_t cnt_i,
    input  wire art_byte_t duty_i,
    // controls
    input  wire logic      oe_i,
    input  wire logic      pol_i,
    input  wire logic      halt_i,
    // pin
    output logic           pwm_o,
    output logic           pwm_oe_o
);
    art_byte_t cmp_r;
    logic      pwm_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cmp_r <= `ART_RST_BYTE;
        end else if (ovf_i) begin
            cmp_r <= duty_i;
        end
    end

    // high at or below compare, evaluated on the live count
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwm_r <= 1'b0;
        end else if (!halt_i) begin
            pwm_r <= (cnt_i <= cmp_r);
        end
    end

    // polarity acts at once; push-pull drive; idle in halt
    assign pwm_o    = oe_i & ~halt_i & (pwm_r ^ pol_i);
    assign pwm_oe_o = oe_i & ~halt_i;
endmodule : art_pwm_chan

/* File: hdl/art_timer.sv */
// auto-reload pwm timer: counter, prescaler, control registers, four pwm channels
// assumes a byte register port and an external event clock synchronous to sys_clk_i
//
// Notes on behaviour
// - counter advances on each prescaler tick
// - counter readable and writable while counting
// - overflow reloads counter, prescaler untouched
// - tap select divides by two power field
// - prescaler fed by cpu or external clock
// - enable clear freezes prescaler and counter
// - reset clears counter, prescaler, selects cpu
// - counter initialisation also clears prescaler
// - prescaler has no software access
// - hidden compare loaded from duty at overflow
// - enabled channel drives its pin push-pull
// - period is 256 minus reload value
// - overflow sets pin to polarity level
// - compare match returns pin opposite level
// - resolution one step in period
// - overflow sets flag, may request interrupt
// - reading control register clears flag
// - pwm stops during halt mode
// - timer can wake from wait and halt
// - event mode counts external events to overflow
// - event count equals 256 minus reload
// - polarity 0 high at or below compare
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer
    import art_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_n_i,
    // register port
    input  wire logic [`ART_ADDR_W-1:0] reg_addr_i,
    input  wire art_byte_t             reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output art_byte_t                  reg_rdata_o,
    // external event clock
    input  wire logic                  external_event_clock_i,
    // chip power state
    input  wire logic                  halt_mode_i,
    // pins and events
    output logic [CHANNELS-1:0]        pwm_channel_pin_o,
    output logic [CHANNELS-1:0]        pwm_channel_pin_oe_o,
    output logic                       overflow_irq_o,
    output logic                       wakeup_o
);
    // pwm output control register holds four enable and four polarity bits
    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
        $error("channel count must be 1 to 4");
    end

    function automatic logic hit(input logic [`ART_ADDR_W-1:0] a, input logic [`ART_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // control state
    logic                clock_source_select_r;
    art_tap_t            prescale_select_r;
    logic                counter_enable_bit_r;
    logic                overflow_irq_enable_r;
    logic                overflow_flag_r;
    art_byte_t           counter_r;
    art_byte_t           reload_value_r;
    logic [CHANNELS-1:0] channel_output_enable_r;
    logic [CHANNELS-1:0] channel_polarity_r;
    art_byte_t           duty_cycle_r [CHANNELS];
    logic                wake_en_r;
    art_byte_t           rdata_r;

    // external edge detection, ticks, write strobes and overflow
    art_ext_state_t      ext_state_r;
    logic                ext_rise;
    logic                input_tick;
    logic                count_tick;
    logic                force_reload;
    logic                car_write;
    logic                csr_write;
    logic                overflow;

    assign csr_write    = reg_wr_i & hit(reg_addr_i, `ART_OFF_CSR);
    assign car_write    = reg_wr_i & hit(reg_addr_i, `ART_OFF_CAR);
    // forced reload only takes effect with enable set in the same write
    assign force_reload = csr_write & reg_wdata_i[`ART_CSR_FORCE_RELOAD_BIT] & reg_wdata_i[`ART_CSR_TCE];

    // external input rising edge as an input tick
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ext_state_r <= ART_EXT_LOW;
        end else begin
            unique case (ext_state_r)
                ART_EXT_LOW: begin
                    if (external_event_clock_i) ext_state_r <= ART_EXT_HIGH;
                end
                ART_EXT_HIGH: begin
                    if (!external_event_clock_i) ext_state_r <= ART_EXT_LOW;
                end
            endcase
        end
    end
    assign ext_rise = (ext_state_r == ART_EXT_LOW) & external_event_clock_i;

    assign input_tick = counter_enable_bit_r & (clock_source_select_r ? ext_rise : 1'b1);

    art_prescaler #(
        .PSC_W        (7)
    ) u_psc (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .tick_i       (input_tick),
        .clear_i      (force_reload | car_write),
        .tap_i        (prescale_select_r),
        .count_tick_o (count_tick)
    );

    // overflow when counting past the top
    assign overflow = count_tick & (counter_r == `ART_CNT_MAX) & ~force_reload & ~car_write;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            counter_r <= `ART_RST_BYTE;
        end else if (car_write) begin
            counter_r <= reg_wdata_i;
        end else if (force_reload) begin
            counter_r <= reload_value_r;
        end else if (overflow) begin
            counter_r <= reload_value_r;
        end else if (count_tick) begin
            counter_r <= counter_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clock_source_select_r <= 1'b0;
            prescale_select_r     <= 3'h0;
            counter_enable_bit_r  <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
        end else if (csr_write) begin
            clock_source_select_r <= reg_wdata_i[`ART_CSR_CLOCK_SOURCE_SELECT];
            prescale_select_r     <= reg_wdata_i[`ART_CSR_CC_HI:`ART_CSR_CC_LO];
            counter_enable_bit_r  <= reg_wdata_i[`ART_CSR_TCE];
            overflow_irq_enable_r <= reg_wdata_i[`ART_CSR_OIE];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            overflow_flag_r <= 1'b0;
        end else if (overflow) begin
            overflow_flag_r <= 1'b1;
        end else if (reg_rd_i && hit(reg_addr_i, `ART_OFF_CSR)) begin
            overflow_flag_r <= 1'b0;
        end
    end

    // other byte registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reload_value_r          <= `ART_RST_BYTE;
            channel_output_enable_r <= '0;
            channel_polarity_r      <= '0;
            wake_en_r               <= 1'b0;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, `ART_OFF_ARR)) reload_value_r <= reg_wdata_i;
            if (hit(reg_addr_i, `ART_OFF_PWM_OUTPUT_CTRL_REG)) begin
                channel_output_enable_r <= reg_wdata_i[`ART_PWM_OUTPUT_CTRL_REG_OE_LO +: CHANNELS];
                channel_polarity_r      <= reg_wdata_i[CHANNELS-1:0];
            end
            if (hit(reg_addr_i, `ART_OFF_MODE)) wake_en_r <= reg_wdata_i[`ART_MODE_WAKE_EN];
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    duty_cycle_r[g] <= `ART_RST_BYTE;
                end else if (reg_wr_i && hit(reg_addr_i, `ART_OFF_DCR0 + `ART_ADDR_W'(g))) begin
                    duty_cycle_r[g] <= reg_wdata_i;
                end
            end

            art_pwm_chan u_ch (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .ovf_i     (overflow),
                .cnt_i     (counter_r),
                .duty_i    (duty_cycle_r[g]),
                .oe_i      (channel_output_enable_r[g]),
                .pol_i     (channel_polarity_r[g]),
                .halt_i    (halt_mode_i),
                .pwm_o     (pwm_channel_pin_o[g]),
                .pwm_oe_o  (pwm_channel_pin_oe_o[g])
            );
        end
    endgenerate

    // read data, one cycle after the strobe; force-reload bit reads zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= `ART_RST_BYTE;
        end else if (reg_rd_i) begin
            rdata_r <= `ART_RST_BYTE;
            if (hit(reg_addr_i, `ART_OFF_CSR)) begin
                rdata_r <= {clock_source_select_r, prescale_select_r, counter_enable_bit_r,
                            1'b0, overflow_irq_enable_r, overflow_flag_r};
            end
            if (hit(reg_addr_i, `ART_OFF_CAR)) rdata_r <= counter_r;
            if (hit(reg_addr_i, `ART_OFF_ARR)) rdata_r <= reload_value_r;
            if (hit(reg_addr_i, `ART_OFF_PWM_OUTPUT_CTRL_REG)) begin
                rdata_r[`ART_PWM_OUTPUT_CTRL_REG_OE_LO +: CHANNELS] <= channel_output_enable_r;
                rdata_r[CHANNELS-1:0]                 <= channel_polarity_r;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (hit(reg_addr_i, `ART_OFF_DCR0 + i[`ART_ADDR_W-1:0])) rdata_r <= duty_cycle_r[i];
            end
            if (hit(reg_addr_i, `ART_OFF_MODE)) begin
                rdata_r[`ART_MODE_HALT]    <= halt_mode_i;
                rdata_r[`ART_MODE_WAKE_EN] <= wake_en_r;
            end
        end
    end
    assign reg_rdata_o = rdata_r;

    // level request while flag and enable
    assign overflow_irq_o = overflow_flag_r & overflow_irq_enable_r;
    // wake request from the pending overflow
    assign wakeup_o = wake_en_r & overflow_flag_r;
endmodule : art_timer

/* File: inc/art_params.svh */
// constants for the auto-reload pwm timer: register offsets, field positions, reset values
// assumes a byte-wide register port with a small index address
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH

`define ART_ADDR_W        4
`define ART_OFF_CSR       4'h0
`define ART_OFF_CAR       4'h1
`define ART_OFF_ARR       4'h2
`define ART_OFF_PWM_OUTPUT_CTRL_REG     4'h3
`define ART_OFF_DCR0      4'h4
`define ART_OFF_MODE      4'h8

`define ART_CSR_CLOCK_SOURCE_SELECT      7
`define ART_CSR_CC_HI     6
`define ART_CSR_CC_LO     4
`define ART_CSR_TCE       3
`define ART_CSR_FORCE_RELOAD_BIT      2
`define ART_CSR_OIE       1
`define ART_CSR_OVF       0

`define ART_PWM_OUTPUT_CTRL_REG_OE_LO   4
`define ART_MODE_HALT     0
`define ART_MODE_WAKE_EN  1

`define ART_RST_BYTE      8'h00
`define ART_CNT_MAX       8'hff
`define ART_PSC_ZERO      7'h00
`define ART_PSC_ONE       7'h01

`endif

/* File: inc/art_pkg.sv */
// types shared by the auto-reload pwm timer modules
package art_pkg;
    typedef logic [7:0] art_byte_t;
    typedef logic [2:0] art_tap_t;
    // external clock edge detector state, gray along idle -> seen-high
    typedef enum logic [1:0] {
        ART_EXT_LOW  = 2'b00,
        ART_EXT_HIGH = 2'b01
    } art_ext_state_t;
endpackage : art_pkg

/* File: tb/art_pin_model.sv */
// pin-side partner: external event source and pwm pin observer
// assumes pins and enables settle between clock edges
`timescale 1ns/1ps
module art_pin_model (
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] pin_i,
    input  wire logic [3:0] oe_i,
    output logic            ext_clk_o
);
    initial ext_clk_o = 1'b0;
    // line idles low, no stray edges
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            ext_clk_o <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            ext_clk_o <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask : pulse
    // counts driven-high cycles per channel, sampled mid-cycle where pins are settled
    task automatic measure(input int n, output int hi [4]);
        hi = '{default: 0};
        repeat (n) begin
            @(negedge sys_clk_i);
            for (int c = 0; c < 4; c++) hi[c] += int'(pin_i[c] & oe_i[c]);
        end
    endtask : measure
endmodule : art_pin_model

/* File: tb/art_timer_monitor.sv */
// port assertions for the auto-reload pwm timer
// assumes the register map of art_params.svh
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer_monitor
    import art_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // clock, reset, register port
    input wire logic                   sys_clk_i,
    input wire logic                   rst_n_i,
    input wire logic [`ART_ADDR_W-1:0] reg_addr_i,
    input wire art_byte_t              reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire art_byte_t              reg_rdata_o,
    // pins and events
    input wire logic                   external_event_clock_i,
    input wire logic                   halt_mode_i,
    input wire logic [CHANNELS-1:0]    pwm_channel_pin_o,
    input wire logic [CHANNELS-1:0]    pwm_channel_pin_oe_o,
    input wire logic                   overflow_irq_o,
    input wire logic                   wakeup_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic csr_rd;
    assign csr_rd = reg_rd_i && reg_addr_i == `ART_OFF_CSR;

    a_halt_no_drive: assert property (halt_mode_i && $past(halt_mode_i) |-> pwm_channel_pin_oe_o == '0)
        else $error("pin driven in halt");
    a_pin_idle_low: assert property ((pwm_channel_pin_o & ~pwm_channel_pin_oe_o) == '0)
        else $error("undriven pin not low");
    a_irq_holds: assert property (overflow_irq_o && !csr_rd && !reg_wr_i |=> overflow_irq_o)
        else $error("irq dropped without clear");
    a_irq_in_csr: assert property (csr_rd && overflow_irq_o |=> reg_rdata_o[1:0] == 2'b11)
        else $error("flag or enable missing");
    a_force_reload_bit_reads_zero: assert property (csr_rd |=> !reg_rdata_o[`ART_CSR_FORCE_RELOAD_BIT])
        else $error("reload bit read back");
    a_no_psc_reg: assert property (reg_rd_i && reg_addr_i > `ART_OFF_MODE |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_halt_visible: assert property (reg_rd_i && reg_addr_i == `ART_OFF_MODE
        |=> reg_rdata_o[0] == $past(halt_mode_i))
        else $error("halt state misread");
    a_wake_flag: assert property (wakeup_o && csr_rd |=> reg_rdata_o[0])
        else $error("wake without flag");

    c_irq: cover property (overflow_irq_o);
    c_halt: cover property (halt_mode_i);
    c_pin: cover property (|pwm_channel_pin_o);
endmodule : art_timer_monitor

bind art_timer art_timer_monitor #(.CHANNELS(CHANNELS)) art_timer_monitor_inst (.sys_clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .external_event_clock_i, .halt_mode_i,
    .pwm_channel_pin_o, .pwm_channel_pin_oe_o, .overflow_irq_o, .wakeup_o);

/* File: tb/test_art_timer.sv */
// self-checking bench for the auto-reload pwm timer
// assumes the partner model drives the event clock
`timescale 1ns/1ps
`include "art_params.svh"
module test_art_timer
    import art_pkg::*;
;
    logic                   sys_clk, rst_n, reg_wr, reg_rd, halt_mode, ext_clk, irq, wake;
    logic [`ART_ADDR_W-1:0] reg_addr;
    art_byte_t              reg_wdata, reg_rdata, a, b;
    logic [3:0]             pins, pins_oe;
    int                     num_errors = 0;
    int                     compares = 0;
    int                     hi [4];
    art_byte_t              exp_hi [4] = '{8'h08, 8'h0c, 8'h04, 8'h10};
    art_byte_t              duty [4] = '{8'hfd, 8'hfe, 8'hfe, 8'hff};

    art_timer #(.CHANNELS(4)) art_timer_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .external_event_clock_i(ext_clk), .halt_mode_i(halt_mode), .pwm_channel_pin_o(pins),
        .pwm_channel_pin_oe_o(pins_oe), .overflow_irq_o(irq), .wakeup_o(wake));
    art_pin_model art_pin_model_inst (.sys_clk_i(sys_clk), .pin_i(pins), .oe_i(pins_oe), .ext_clk_o(ext_clk));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic results;
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input art_byte_t got, input art_byte_t exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] ad, input art_byte_t v);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, output art_byte_t v);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic rdc(input logic [3:0] ad, input art_byte_t exp);
        art_byte_t v;
        rd(ad, v);
        chk(v, exp);
    endtask : rdc

    task automatic t_reset;
        rdc(`ART_OFF_CSR, 8'h00);
        rdc(`ART_OFF_CAR, 8'h00);
        rdc(4'hf, 8'h00);
        chk({4'h0, pins_oe}, 8'h00);
    endtask : t_reset
    task automatic t_prescale;
        wr(`ART_OFF_ARR, 8'h00);
        wr(`ART_OFF_CAR, 8'h00);
        for (int cc = 0; cc < 8; cc++) begin
            wr(`ART_OFF_CSR, {1'b0, 3'(cc), 4'h8});
            rd(`ART_OFF_CAR, a);
            repeat (8 * 2 ** cc - 2) @(posedge sys_clk);
            rd(`ART_OFF_CAR, b);
            chk(b - a, 8'h08);
        end
        wr(`ART_OFF_CSR, 8'h00);
        rd(`ART_OFF_CAR, a);
        repeat (20) @(posedge sys_clk);
        rdc(`ART_OFF_CAR, a);
        wr(`ART_OFF_CSR, 8'h78);
        wr(`ART_OFF_CAR, 8'h40);
        rdc(`ART_OFF_CAR, 8'h40);
        wr(`ART_OFF_ARR, 8'h20);
        wr(`ART_OFF_CSR, 8'h7c);
        rdc(`ART_OFF_CAR, 8'h20);
    endtask : t_prescale
    task automatic t_event;
        wr(`ART_OFF_ARR, 8'hfd);
        wr(`ART_OFF_CSR, 8'h8a);
        wr(`ART_OFF_CAR, 8'hfd);
        rd(`ART_OFF_CSR, a);
        art_pin_model_inst.pulse(2);
        rdc(`ART_OFF_CAR, 8'hff);
        rdc(`ART_OFF_CSR, 8'h8a);
        art_pin_model_inst.pulse(1);
        chk({7'h0, irq}, 8'h01);
        rdc(`ART_OFF_CAR, 8'hfd);
        wr(`ART_OFF_MODE, 8'h02);
        #1 chk({7'h0, wake}, 8'h01);
        rdc(`ART_OFF_CSR, 8'h8b);
        rdc(`ART_OFF_CSR, 8'h8a);
    endtask : t_event
    task automatic t_pwm;
        wr(`ART_OFF_CSR, 8'h08);
        wr(`ART_OFF_ARR, 8'hfc);
        for (int c = 0; c < 4; c++) wr(4'(`ART_OFF_DCR0 + c), duty[c]);
        wr(`ART_OFF_PWM_OUTPUT_CTRL_REG, 8'hf4);
        repeat (8) @(posedge sys_clk);
        chk({4'h0, pins_oe}, 8'h0f);
        art_pin_model_inst.measure(16, hi);
        for (int c = 0; c < 4; c++) chk(8'(hi[c]), exp_hi[c]);
        wr(`ART_OFF_DCR0, 8'hfe);
        repeat (8) @(posedge sys_clk);
        art_pin_model_inst.measure(16, hi);
        chk(8'(hi[0]), 8'h0c);
        wr(`ART_OFF_CSR, 8'h00);
        halt_mode <= 1'b1;
        art_pin_model_inst.measure(16, hi);
        chk(8'(hi[0] + hi[1] + hi[2] + hi[3]), 8'h00);
        rdc(`ART_OFF_MODE, 8'h03);
        halt_mode <= 1'b0;
        // full resolution period, 100% and 0% by polarity
        wr(`ART_OFF_CSR, 8'h08);
        wr(`ART_OFF_ARR, 8'h00);
        wr(`ART_OFF_DCR0, 8'hff);
        wr(`ART_OFF_PWM_OUTPUT_CTRL_REG, 8'h10);
        repeat (270) @(posedge sys_clk);
        art_pin_model_inst.measure(16, hi);
        chk(8'(hi[0]), 8'h10);
        wr(`ART_OFF_PWM_OUTPUT_CTRL_REG, 8'h11);
        art_pin_model_inst.measure(16, hi);
        chk(8'(hi[0]), 8'h00);
    endtask : t_pwm

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        halt_mode = 1'b0;
        reg_addr = '0;
        reg_wdata = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_prescale();
        t_event();
        t_pwm();
        results();
    end
    initial begin
        #(20000 * 40);
        num_errors++;
        results();
    end
endmodule : test_art_timer
